// >>> hw/rsic_pkg.sv
// Shared constants and types for the reset and external interrupt conditioner
package rsic_pkg;

    // ****************************************************************
    // Register map (byte addresses on the Wishbone bus)
    // ****************************************************************
    localparam int unsigned ADDR_W    = 8;      // Slave address width
    localparam logic [7:0]  OFS_CTRL  = 8'h00;  // Trigger mode per input
    localparam logic [7:0]  OFS_PUDR  = 8'h04;  // Pull-up disable bits
    localparam logic [7:0]  OFS_STAT  = 8'h08;  // Sticky event flags
    localparam logic [7:0]  OFS_MASK  = 8'h0C;  // Interrupt enables
    localparam logic [7:0]  OFS_STATE = 8'h10;  // Live block state

    // ****************************************************************
    // Field positions and widths
    // ****************************************************************
    localparam int unsigned CTRL_W      = 2;  // One edge-mode bit per input
    localparam int unsigned PUD_W       = 3;
    localparam int unsigned PUD_IRQ     = 0;  // Interrupt pins pull-up off
    localparam int unsigned PUD_RESET   = 1;  // Reset pin pull-up off
    localparam int unsigned PUD_BOOT    = 2;  // Boot select pull-up off
    localparam int unsigned EV_W        = 3;
    localparam int unsigned EV_RSTREL   = 2;  // Bits 0/1 are inputs A/B
    localparam int unsigned ST_W        = 6;
    localparam int unsigned ST_BOOT     = 2;  // Bits 0/1 are pin levels
    localparam int unsigned ST_BOOT_SOURCE_SELECT_IN  = 3;
    localparam int unsigned ST_LOWPWR   = 4;
    localparam int unsigned ST_INTRST   = 5;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;  // Level mode
    localparam logic [PUD_W-1:0]  PUD_RST  = 3'h0;  // All pull-ups on
    localparam logic [EV_W-1:0]   MASK_RST = 3'h0;
    localparam int unsigned RST_STRETCH_CYC = 16;   // Release delay, cycles

    // Reset sequencer states, one-hot
    typedef enum logic [2:0] {
        RS_HOLD    = 3'h1,
        RS_STRETCH = 3'h2,
        RS_RUN     = 3'h4
    } rsic_rst_e;

endpackage : rsic_pkg

// >>> hw/rsic_irq_cond.sv
// Conditioner for one external interrupt request pin
`timescale 1ns/100ps
module rsic_irq_cond
    import rsic_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pinN,      // Raw active-low request pin
    input  wire logic edgeMode,  // 1: falling edge, 0: level
    output logic      pinLevel,  // Synchronised pin level
    output logic      reqEvent   // Request seen this cycle
);

    // ****************************************************************
    // Synchroniser and edge history
    // ****************************************************************
    logic sync1_q;  // Metastable stage, read by sync2_q only
    logic sync2_q;  // Safe pin level
    logic prev_q;   // Level one cycle earlier
    logic fallEdge;

    // Two flops then history; idle level is high (pull-up)
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1_q <= 1'h1;
            sync2_q <= 1'h1;
            prev_q  <= 1'h1;
        end
        else
        begin
            sync1_q <= pinN;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign pinLevel = sync2_q;
    assign fallEdge = prev_q & ~sync2_q;
    // Edge mode pulses once; level mode asserts while held low
    assign reqEvent = edgeMode ? fallEdge : ~sync2_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_level_req;
        @(posedge clk) disable iff (reset)
        (!edgeMode && reqEvent) |-> !$past(pinN, 2);
    endproperty
    a_level_req: assert property (p_level_req)
        else $error("level request without low pin two cycles back");

    property p_edge_req;
        @(posedge clk) disable iff (reset)
        (edgeMode && reqEvent) |-> (!$past(pinN, 2) && $past(pinN, 3));
    endproperty
    a_edge_req: assert property (p_edge_req)
        else $error("edge request without a falling pin");

endmodule : rsic_irq_cond

// >>> hw/rsic_reset_seq.sv
// Reset pin sequencer: hold, stretched release and boot mode capture
`timescale 1ns/100ps
module rsic_reset_seq
    import rsic_pkg::*;
#(
    parameter int unsigned STRETCH = RST_STRETCH_CYC
)
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic resetPinN,   // Reset pin, active low
    input  wire logic bootSelIn,   // Boot source select pin
    output logic      intReset,    // Internal reset, active high
    output logic      releaseEvt,  // Pulse one cycle before release
    output logic      bootMode     // Captured boot select level
);

    localparam int unsigned CW = $clog2(STRETCH + 1);
    localparam logic [CW-1:0] LAST = CW'(STRETCH - 1);

    rsic_rst_e       state_q;   // Sequencer state
    logic [CW-1:0]   cnt_q;     // Stretch counter
    logic            pinPrev_q; // Pin level last cycle
    logic            boot_q;    // Latched boot mode
    logic            pinRise;

    // ****************************************************************
    // Release sequencer
    // ****************************************************************
    // Pin low forces hold at every edge; counting starts only once high
    always_ff @(posedge clk)
    begin
        if (reset || !resetPinN)
        begin
            state_q <= RS_HOLD;
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                RS_HOLD:
                    state_q <= RS_STRETCH;
                RS_STRETCH:
                    // Fixed delay, then release on a clock edge
                    if (cnt_q == LAST)
                        state_q <= RS_RUN;
                    else
                        cnt_q <= cnt_q + CW'(1);
                RS_RUN:
                    state_q <= RS_RUN;
                default:
                    state_q <= RS_HOLD;
            endcase
        end
    end

    assign intReset   = (state_q != RS_RUN);
    assign releaseEvt = (state_q == RS_STRETCH) && (cnt_q == LAST);

    // ****************************************************************
    // Boot mode capture
    // ****************************************************************
    assign pinRise = !pinPrev_q && resetPinN;

    // Sampled at the first edge the pin is seen high again
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pinPrev_q <= 1'h0;
            boot_q    <= 1'h0;
        end
        else
        begin
            pinPrev_q <= resetPinN;
            if (pinRise)
                boot_q <= bootSelIn;
        end
    end

    assign bootMode = boot_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_hold;
        @(posedge clk) disable iff (reset)
        !resetPinN |=> intReset ##1 intReset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("internal reset dropped while pin low");

    property p_stretch;
        @(posedge clk) disable iff (reset)
        $fell(intReset) |-> ($past(resetPinN, STRETCH) && $past(resetPinN));
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("internal reset released too early");

    property p_boot;
        @(posedge clk) disable iff (reset)
        pinRise |=> (bootMode == $past(bootSelIn));
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot select not captured at release");

endmodule : rsic_reset_seq

// >>> hw/rsic_top.sv
// Top of the reset and external interrupt conditioner with Wishbone slave
//
// Contract
// - Stop/wait modes accept interrupt pins asynchronously
// - Other modes synchronise interrupt pins first
// - Each interrupt pin: level or falling edge
// - Interrupt pull-up on at reset, disable bit
// - Reset pin low holds device in reset
// - Boot select latched when reset pin released
// - Internal reset released after fixed clock count
// - Reset output follows internal reset state
// - High boot select means external boot unless secured
// - Reset pin pull-up, software disable bit
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
module rsic_top
    import rsic_pkg::*;
#(
    parameter int unsigned STRETCH = RST_STRETCH_CYC
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    // Wishbone classic slave
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    output logic                   ack_o,
    // Pins and core status
    input  wire logic              ext_irq_a_in,
    input  wire logic              ext_irq_b_in,
    input  wire logic              resetPinN,
    input  wire logic              boot_source_select_in,
    input  wire logic              flashSecured,
    input  wire logic              stopMode,
    input  wire logic              waitMode,
    // Outputs
    output logic                   reset_out,
    output logic                   bootFromExternal,
    output logic                   wakeReq,
    output logic                   irqPullupEn,
    output logic                   resetPullupEn,
    output logic                   bootPullupEn,
    output logic                   irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [CTRL_W-1:0]     ctrl_q;               // Edge mode per input
    logic [PUD_W-1:0]      pullup_disable_reg_q; // Pull-up disable bits
    logic [EV_W-1:0]       status_q;             // Sticky events
    logic [EV_W-1:0]       status_d;
    logic [EV_W-1:0]       mask_q;               // Interrupt enables
    logic                  ack_q;                // Bus answer
    logic [31:0]           rdata_q;              // Registered read data
    logic [31:0]           rdMux;                // Selected read word
    logic [1:0]            pinsN;                // Raw interrupt pins
    logic [1:0]            pinLevel;             // Synchronised levels
    logic [1:0]            reqEvent;             // Request per input
    logic [EV_W-1:0]       events;               // All event sources
    logic [EV_W-1:0]       clrBits;              // Write-one-to-clear
    logic [ST_W-1:0]       stateWord;            // Live state view
    logic                  intReset;
    logic                  releaseEvt;
    logic                  bootMode;
    logic                  lowPower;
    logic                  regReset;
    logic                  busReq;
    logic                  wrTake;
    logic                  selCtrl;
    logic                  selPudr;
    logic                  selStat;
    logic                  selMask;
    logic                  selState;

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    rsic_reset_seq #(
        .STRETCH    (STRETCH)
    ) u_rst (
        .clk        (clk),
        .reset      (reset),
        .resetPinN  (resetPinN),
        .bootSelIn  (boot_source_select_in),
        .intReset   (intReset),
        .releaseEvt (releaseEvt),
        .bootMode   (bootMode)
    );

    // Pin low shows at once; the stretched tail comes from the sequencer
    assign reset_out = intReset | ~resetPinN;

    // Control registers return to defaults under either reset
    assign regReset = reset | reset_out;

    // External boot only when the flash is not locked
    assign bootFromExternal = bootMode & ~flashSecured;

    // ****************************************************************
    // Interrupt pin conditioners
    // ****************************************************************
    assign pinsN = {ext_irq_b_in, ext_irq_a_in};

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_irq
            rsic_irq_cond u_cond (
                .clk      (clk),
                .reset    (reset),
                .pinN     (pinsN[i]),
                .edgeMode (ctrl_q[i]),
                .pinLevel (pinLevel[i]),
                .reqEvent (reqEvent[i])
            );
        end
    endgenerate

    // ****************************************************************
    // Low-power wake path
    // ****************************************************************
    assign lowPower = stopMode | waitMode;

    // Pure gating, no flop: works with the clock stopped.
    // Either trigger mode wakes on a low pin; the clocked path
    // classifies the request once the clock runs again.
    assign wakeReq = lowPower & ~(&pinsN);

    // ****************************************************************
    // Pull-up controls
    // ****************************************************************
    // Disable bits clear under reset, so every pull-up starts on
    assign irqPullupEn   = ~pullup_disable_reg_q[PUD_IRQ];
    assign resetPullupEn = ~pullup_disable_reg_q[PUD_RESET];
    assign bootPullupEn  = ~pullup_disable_reg_q[PUD_BOOT];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign busReq   = cyc_i & stb_i;
    assign selCtrl  = (adr_i == OFS_CTRL);
    assign selPudr  = (adr_i == OFS_PUDR);
    assign selStat  = (adr_i == OFS_STAT);
    assign selMask  = (adr_i == OFS_MASK);
    assign selState = (adr_i == OFS_STATE);

    // Write lands at the edge the master sees ack; lane 0 only
    assign wrTake = busReq & ack_q & we_i & sel_i[0];

    // Unmapped addresses still answer, reading zero
    assign stateWord = {intReset, lowPower, bootFromExternal, bootMode,
                        pinLevel};
    assign rdMux = selCtrl  ? {30'h0, ctrl_q} :
                   selPudr  ? {29'h0, pullup_disable_reg_q} :
                   selStat  ? {29'h0, status_q} :
                   selMask  ? {29'h0, mask_q} :
                   selState ? {26'h0, stateWord} :
                   32'h0;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // One-cycle ack, dropped the cycle after; data held with it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ack_q   <= 1'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            ack_q   <= busReq & ~ack_q;
            rdata_q <= rdMux;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Mode, pull-up and mask bits; all cleared by device reset
    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            ctrl_q               <= CTRL_RST;
            pullup_disable_reg_q <= PUD_RST;
            mask_q               <= MASK_RST;
        end
        else if (wrTake)
        begin
            if (selCtrl)
                ctrl_q <= dat_i[CTRL_W-1:0];
            else if (selPudr)
                pullup_disable_reg_q <= dat_i[PUD_W-1:0];
            else if (selMask)
                mask_q <= dat_i[EV_W-1:0];
        end
    end

    // ****************************************************************
    // Sticky status
    // ****************************************************************
    // Requests reach here only through the synchronisers
    assign events  = {releaseEvt, reqEvent};
    assign clrBits = (wrTake && selStat) ? dat_i[EV_W-1:0] : 3'h0;

    // Set beats clear, so a request in the clearing cycle survives.
    // Only the bus reset clears it, else the release flag is lost.
    assign status_d = (status_q & ~clrBits) | events;

    always_ff @(posedge clk)
    begin
        if (reset)
            status_q <= 3'h0;
        else
            status_q <= status_d;
    end

    // Level output while any enabled flag stands
    assign irq = |(status_q & mask_q);

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_wake;
        @(posedge clk) disable iff (reset)
        (lowPower && (!ext_irq_a_in || !ext_irq_b_in)) |-> wakeReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("low pin in low power mode gave no wake");

    property p_nowake;
        @(posedge clk) disable iff (reset)
        !lowPower |-> !wakeReq;
    endproperty
    a_nowake: assert property (p_nowake)
        else $error("async wake outside low power mode");

    property p_pullup;
        @(posedge clk) disable iff (reset)
        !resetPinN |=> (irqPullupEn && resetPullupEn && bootPullupEn);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up off after reset");

    // Two cycles is the floor: a stretch of one still holds the hold edge and one count
    property p_rstout;
        @(posedge clk) disable iff (reset)
        $rose(resetPinN) |-> reset_out [*2];
    endproperty
    a_rstout: assert property (p_rstout)
        else $error("reset output dropped too soon");

    property p_boot_source_select_in;
        @(posedge clk) disable iff (reset)
        (bootMode && !flashSecured) |-> bootFromExternal;
    endproperty
    a_boot_source_select_in: assert property (p_boot_source_select_in)
        else $error("external boot not selected");

    property p_setwins;
        @(posedge clk) disable iff (reset)
        (reqEvent[0] && wrTake && selStat && dat_i[0]) |=> status_q[0];
    endproperty
    a_setwins: assert property (p_setwins)
        else $error("event lost in clearing cycle");

    property p_ack;
        @(posedge clk) disable iff (reset)
        (busReq && !ack_q) |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack not a single cycle pulse");

endmodule : rsic_top

// >>> verif/rsic_pin_model.sv
// Pin-side model of the reset supervisor, boot strap and interrupt requesters
`timescale 1ns/100ps
module rsic_pin_model
(
    input  wire logic clk,
    input  wire logic holdReset,    // Supervisor asserts the reset pin
    input  wire logic bootHigh,     // Strap level of the boot select pin
    input  wire logic reqA,         // Requester A pulls its line low
    input  wire logic reqB,         // Requester B pulls its line low
    input  wire logic irqPullupEn,  // Device pull-up on the request lines
    output logic      irqAN,
    output logic      irqBN,
    output logic      resetPinN,
    output logic      bootSel
);
    // ****************************************************************
    // Open-drain request lines
    // ****************************************************************
    logic flipQ = 1'b0;  // Floating-line pattern

    // Changes every cycle so a released line without pull-up never looks settled
    always_ff @(posedge clk)
        flipQ <= ~flipQ;

    // Low while requesting, otherwise pull-up or float
    assign irqAN = reqA ? 1'b0 : (irqPullupEn ? 1'b1 : flipQ);
    assign irqBN = reqB ? 1'b0 : (irqPullupEn ? 1'b1 : flipQ);

    // Push-pull supervisor and hard-tied strap
    assign resetPinN = ~holdReset;
    assign bootSel   = bootHigh;
endmodule : rsic_pin_model

// >>> verif/testbench.sv
// Self-checking bench of the reset and interrupt conditioner
`timescale 1ns/100ps
module testbench;
    import rsic_pkg::*;
    localparam int unsigned STRETCH = 4;  // Short stretch keeps the run brief
    logic              clk      = 1'b0;
    logic              reset    = 1'b1;
    logic [ADDR_W-1:0] adr      = 8'h00;
    logic [31:0]       datW     = 32'h0;
    logic [31:0]       datR;
    logic [31:0]       rd;
    logic              we       = 1'b0;
    logic              cyc      = 1'b0;
    logic              stb      = 1'b0;
    logic              holdRst  = 1'b1;
    logic              bootHigh = 1'b0;
    logic              reqA     = 1'b0;
    logic              reqB     = 1'b0;
    logic              flashSec = 1'b0;
    logic              stopM    = 1'b0;
    logic              waitM    = 1'b0;
    logic              ack, pinA, pinB, pinRst, pinBoot, rstOut, bootExt, wake, irqPu, rstPu, bootPu, irqOut;
    int                miscompares = 0;
    int                checks      = 0;
    int                cycles      = 0;

    always #12.5 clk = ~clk;

    rsic_top #(.STRETCH(STRETCH)) rsic_top_i (.clk(clk), .reset(reset), .adr_i(adr), .dat_i(datW),
        .dat_o(datR), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
        .ext_irq_a_in(pinA), .ext_irq_b_in(pinB), .resetPinN(pinRst), .boot_source_select_in(pinBoot),
        .flashSecured(flashSec), .stopMode(stopM), .waitMode(waitM), .reset_out(rstOut),
        .bootFromExternal(bootExt), .wakeReq(wake), .irqPullupEn(irqPu), .resetPullupEn(rstPu),
        .bootPullupEn(bootPu), .irq(irqOut));
    rsic_pin_model rsic_pin_model_i (.clk(clk), .holdReset(holdRst), .bootHigh(bootHigh), .reqA(reqA),
        .reqB(reqB), .irqPullupEn(irqPu), .irqAN(pinA), .irqBN(pinB), .resetPinN(pinRst), .bootSel(pinBoot));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic cycle; request held until ack is sampled, data taken there
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datW <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_of_test;
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Pin reset hold, stretched release, boot capture, pull-ups back on
    task t_release(input logic boot, input logic sec);
        int n;
        @(posedge clk);
        holdRst  <= 1'b1;
        bootHigh <= boot;
        flashSec <= sec;
        #1 check("reset_out held", rstOut, 32'h1);
        repeat (3) @(posedge clk);
        check("pull-ups in reset", {bootPu, rstPu, irqPu}, 32'h7);
        holdRst <= 1'b0;
        n = 1;  // The first high edge moves hold to stretch
        @(posedge clk);
        while (rstOut === 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("release stretch", n, STRETCH + 1);
        check("boot mode", bootExt, boot && !sec);
        wb(1'b0, OFS_STAT, 32'h0);
        check("release event", rd[EV_RSTREL], 32'h1);
        wb(1'b1, OFS_STAT, 32'h7);
        $display("test release done");
    endtask : t_release

    // Reset values, pull-up disables, unmapped read
    task t_pullup;
        wb(1'b0, OFS_PUDR, 32'h0);
        check("pudr reset", rd, 32'h0);
        wb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        wb(1'b1, OFS_PUDR, 32'h7);
        #1 check("pull-ups off", {bootPu, rstPu, irqPu}, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("test pullup done");
    endtask : t_pullup

    // One pin in one trigger mode: sync delay, re-flag, mask, clear
    task t_trigger(input int c, input logic edgeM);
        wb(1'b1, OFS_CTRL, {31'h0, edgeM} << c);
        wb(1'b1, OFS_MASK, 32'h1 << c);
        wb(1'b1, OFS_STAT, 32'h7);
        #1 check("irq idle", irqOut, 32'h0);
        @(posedge clk);
        if (c == 1) reqB <= 1'b1; else reqA <= 1'b1;
        @(posedge clk);
        #1 check("not before sync", irqOut, 32'h0);
        repeat (6) @(posedge clk);
        check("request flagged", irqOut, 32'h1);
        wb(1'b1, OFS_STAT, 32'h7);
        wb(1'b0, OFS_STAT, 32'h0);
        check("re-flag while low", rd[c], !edgeM);
        wb(1'b1, OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        check("masked", irqOut, 32'h0);
        if (c == 1) reqB <= 1'b0; else reqA <= 1'b0;
        repeat (5) @(posedge clk);
        wb(1'b1, OFS_STAT, 32'h7);
        wb(1'b0, OFS_STAT, 32'h0);
        check("cleared", rd, 32'h0);
        $display("test trigger done");
    endtask : t_trigger

    // Wake with no clock edge in between, stop and wait
    task t_lowpower;
        @(posedge clk);
        stopM <= 1'b1;
        reqA  <= 1'b1;
        #1 check("stop wake", wake, 32'h1);
        @(posedge clk);
        stopM <= 1'b0;
        waitM <= 1'b1;
        reqA  <= 1'b0;
        reqB  <= 1'b1;
        #1 check("wait wake", wake, 32'h1);
        @(posedge clk);
        waitM <= 1'b0;
        reqB  <= 1'b0;
        #1 check("no wake in run", wake, 32'h0);
        $display("test lowpower done");
    endtask : t_lowpower

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_release(1'b1, 1'b0);
        t_pullup;
        t_release(1'b0, 1'b0);
        t_release(1'b1, 1'b1);
        t_trigger(0, 1'b0);
        t_trigger(1, 1'b1);
        t_trigger(0, 1'b1);
        t_trigger(1, 1'b0);
        t_lowpower;
        end_of_test;
    end
endmodule : testbench
